// File: hw/rtcc_regs.svh
// Register offsets, field positions and reset values of the real time clock chain.
`ifndef RTCC_REGS_SVH
`define RTCC_REGS_SVH
`define RTCC_ADDR_W          16
`define RTCC_OFF_CTRL        16'h0000
`define RTCC_OFF_PRESCALER   16'h0004
`define RTCC_OFF_PRE_RELOAD  16'h0008
`define RTCC_OFF_COUNT_LO    16'h000c
`define RTCC_OFF_COUNT_HI    16'h0010
`define RTCC_OFF_RELOAD_LO   16'h0014
`define RTCC_OFF_RELOAD_HI   16'h0018
`define RTCC_OFF_SUBNODE     16'hf10c
`define RTCC_OFF_NODE        16'hf1a0
`define RTCC_CTRL_RUN_BIT    0
`define RTCC_CTRL_PRE_BIT    1
`define RTCC_CTRL_SRST_BIT   2
`define RTCC_CTRL_RST        2'h3
`define RTCC_SUBNODE_RST     10'h000
`define RTCC_NODE_RST        9'h000
`define RTCC_PRESCALER_RST   16'h0000
`define RTCC_RELOAD_RST      16'h0000
`define RTCC_COUNT_RST       32'h0000_0000
`define RTCC_SUBNODE_W       10
`define RTCC_NODE_W          9
`endif

// File: hw/rtcc_pkg.sv
// Types shared by the real time clock chain.
package rtcc_pkg;
  typedef struct packed {
    logic pre_en;
    logic run;
  } rtcc_ctrl_t;
  typedef struct packed {
    logic       group_extension_bit;
    logic       node_request_bit;
    logic       node_enable_bit;
    logic [3:0] irq_level_field;
    logic [1:0] group_level_field;
  } rtcc_node_t;
endpackage : rtcc_pkg

// File: hw/rtcc_top.sv
// Real time clock counter chain with interrupt subnode and APB register access.
//
// Contract
// - Prescaler and four sections form 48-bit chain.
// - Zero reloads give a pure binary counter.
// - Each timer restarts from reload after overflow.
// - Prescaler reload zero divides by 65536.
// - Chain registers survive system reset.
// - Chain registers undefined until soft reset.
// - Every overflow raises that timer's request.
// - Overflow sets its own subnode request flag.
// - Enabled flags are ORed onto common line.
// - Hardware never clears subnode request flags.
// - Node request bit clears on CPU vector.
// - Prescaler enable bit 0, flag bit 1.
// - Section enables 2,4,6,8; flags 3,5,7,9.
// - Node register resets on system reset.
// - Section overflow pulses next section, reloads itself.
// - Prescaler enable divides input ticks by PRESCALE_DIV, default eight.
// - Soft reset restores chain registers, clears itself.
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_regs.svh"

module rtcc_top #(
  parameter int PRESCALE_DIV = 8
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic        RTC_TICK_IN,
  input  wire logic        IRQ_ACK_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [15:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output var  logic [31:0] PRDATA_OUT,
  output var  logic        PREADY_OUT,
  output var  logic        PSLVERR_OUT,
  output var  logic        IRQ_OUT
);

  localparam int DIV_W = $clog2(PRESCALE_DIV);

  generate
    if (PRESCALE_DIV < 2 || (PRESCALE_DIV & (PRESCALE_DIV - 1)) != 0)
    begin : g_bad_div
      $error("PRESCALE_DIV must be a power of two of at least 2");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops.

  logic rst_meta_r;
  logic rst_b_r;

  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      rst_meta_r <= 1'b0;
      rst_b_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_b_r    <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register decode.

  logic        acc_setup;
  logic        wr_en;
  logic        hit;
  logic [31:0] rd_data;

  rtcc_pkg::rtcc_ctrl_t       ctrl_r;
  rtcc_pkg::rtcc_ctrl_t       ctrl_nxt;
  logic [15:0]                pre_r;
  logic [15:0]                pre_nxt;
  logic [15:0]                pre_rel_r;
  logic [15:0]                pre_rel_nxt;
  logic [31:0]                cnt_r;
  logic [31:0]                cnt_nxt;
  logic [31:0]                rel_r;
  logic [31:0]                rel_nxt;
  logic [`RTCC_SUBNODE_W-1:0] sub_r;
  logic [`RTCC_SUBNODE_W-1:0] sub_nxt;
  logic [DIV_W-1:0]           div_r;
  logic [DIV_W-1:0]           div_nxt;
  rtcc_pkg::rtcc_node_t       node_r;
  rtcc_pkg::rtcc_node_t       node_nxt;
  logic                       srst_r;
  logic                       srst_nxt;
  logic                       line_r;
  logic                       line_nxt;
  logic                       irq_r;
  logic                       irq_nxt;
  logic [31:0]                prdata_r;
  logic [31:0]                prdata_nxt;
  logic                       pready_r;
  logic                       pready_nxt;
  logic                       pslverr_r;
  logic                       pslverr_nxt;

  assign acc_setup = PSEL_IN & ~PENABLE_IN;
  assign wr_en     = PSEL_IN & PENABLE_IN & pready_r & PWRITE_IN & hit;

  always_comb
  begin
    hit     = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (PADDR_IN)
      `RTCC_OFF_CTRL:       rd_data = {29'h0000_0000, srst_r, ctrl_r.pre_en, ctrl_r.run};
      `RTCC_OFF_PRESCALER:  rd_data = {16'h0000, pre_r};
      `RTCC_OFF_PRE_RELOAD: rd_data = {16'h0000, pre_rel_r};
      `RTCC_OFF_COUNT_LO:   rd_data = {16'h0000, cnt_r[15:0]};
      `RTCC_OFF_COUNT_HI:   rd_data = {16'h0000, cnt_r[31:16]};
      `RTCC_OFF_RELOAD_LO:  rd_data = {16'h0000, rel_r[15:0]};
      `RTCC_OFF_RELOAD_HI:  rd_data = {16'h0000, rel_r[31:16]};
      `RTCC_OFF_SUBNODE:    rd_data = {22'h00_0000, sub_r};
      `RTCC_OFF_NODE:       rd_data = {23'h00_0000, node_r};
      default:              hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Counter chain.

  logic       tick_eff;
  logic       pre_ovf;
  logic [4:0] carry;
  logic [3:0] sec_ovf;
  logic [31:0] cnt_step;

  assign tick_eff = ctrl_r.run & RTC_TICK_IN
                  & (~ctrl_r.pre_en | (div_r == DIV_W'(PRESCALE_DIV - 1)));
  assign pre_ovf  = tick_eff & (pre_r == 16'hffff);
  assign carry[0] = pre_ovf;

  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_sec
      localparam int LO = (i == 0) ? 0 : (i == 1) ? 10 : (i == 2) ? 16 : 22;
      localparam int W  = (i == 0 || i == 3) ? 10 : 6;
      assign sec_ovf[i] = carry[i] & (&cnt_r[LO +: W]);
      assign carry[i+1] = sec_ovf[i];
      assign cnt_step[LO +: W] = sec_ovf[i] ? rel_r[LO +: W]
                               : carry[i] ? cnt_r[LO +: W] + W'(1)
                               : cnt_r[LO +: W];
    end
  endgenerate

  always_comb
  begin
    ctrl_nxt    = ctrl_r;
    div_nxt     = div_r;
    pre_nxt     = pre_r;
    pre_rel_nxt = pre_rel_r;
    cnt_nxt     = cnt_step;
    rel_nxt     = rel_r;
    sub_nxt     = sub_r;
    if (ctrl_r.run && ctrl_r.pre_en && RTC_TICK_IN)
    begin
      div_nxt = div_r + DIV_W'(1);
    end
    if (pre_ovf)
    begin
      pre_nxt = pre_rel_r;
    end
    else if (tick_eff)
    begin
      pre_nxt = pre_r + 16'h0001;
    end
    if (wr_en)
    begin
      unique case (PADDR_IN)
        `RTCC_OFF_CTRL:
        begin
          ctrl_nxt.run    = PWDATA_IN[`RTCC_CTRL_RUN_BIT];
          ctrl_nxt.pre_en = PWDATA_IN[`RTCC_CTRL_PRE_BIT];
        end
        `RTCC_OFF_PRESCALER:  pre_nxt          = PWDATA_IN[15:0];
        `RTCC_OFF_PRE_RELOAD: pre_rel_nxt      = PWDATA_IN[15:0];
        `RTCC_OFF_COUNT_LO:   cnt_nxt[15:0]    = PWDATA_IN[15:0];
        `RTCC_OFF_COUNT_HI:   cnt_nxt[31:16]   = PWDATA_IN[15:0];
        `RTCC_OFF_RELOAD_LO:  rel_nxt[15:0]    = PWDATA_IN[15:0];
        `RTCC_OFF_RELOAD_HI:  rel_nxt[31:16]   = PWDATA_IN[15:0];
        `RTCC_OFF_SUBNODE:    sub_nxt          = PWDATA_IN[`RTCC_SUBNODE_W-1:0];
        default:              ctrl_nxt         = ctrl_r;
      endcase
    end
    sub_nxt[1] = sub_nxt[1] | pre_ovf;
    for (int i = 0; i < 4; i++)
    begin
      sub_nxt[2*i+3] = sub_nxt[2*i+3] | sec_ovf[i];
    end
    if (srst_r)
    begin
      ctrl_nxt    = rtcc_pkg::rtcc_ctrl_t'(`RTCC_CTRL_RST);
      div_nxt     = '0;
      pre_nxt     = `RTCC_PRESCALER_RST;
      pre_rel_nxt = `RTCC_PRESCALER_RST;
      cnt_nxt     = `RTCC_COUNT_RST;
      rel_nxt     = {`RTCC_RELOAD_RST, `RTCC_RELOAD_RST};
      sub_nxt     = `RTCC_SUBNODE_RST;
    end
  end

  // These registers have no system reset so that timekeeping runs on through it.
  always_ff @(posedge CLK_IN)
  begin
    ctrl_r    <= ctrl_nxt;
    div_r     <= div_nxt;
    pre_r     <= pre_nxt;
    pre_rel_r <= pre_rel_nxt;
    cnt_r     <= cnt_nxt;
    rel_r     <= rel_nxt;
    sub_r     <= sub_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Interrupt node, soft reset strobe and bus answer.

  logic sub_line;

  always_comb
  begin
    sub_line = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      sub_line = sub_line | (sub_r[2*i] & sub_r[2*i+1]);
    end
  end

  always_comb
  begin
    node_nxt    = node_r;
    srst_nxt    = 1'b0;
    line_nxt    = sub_line;
    prdata_nxt  = prdata_r;
    pready_nxt  = acc_setup;
    pslverr_nxt = 1'b0;
    if (acc_setup)
    begin
      prdata_nxt  = hit ? rd_data : 32'h0000_0000;
      pslverr_nxt = ~hit;
    end
    if (wr_en && PADDR_IN == `RTCC_OFF_NODE)
    begin
      node_nxt = rtcc_pkg::rtcc_node_t'(PWDATA_IN[`RTCC_NODE_W-1:0]);
    end
    if (wr_en && PADDR_IN == `RTCC_OFF_CTRL)
    begin
      srst_nxt = PWDATA_IN[`RTCC_CTRL_SRST_BIT];
    end
    if (IRQ_ACK_IN)
    begin
      node_nxt.node_request_bit = 1'b0;
    end
    if (sub_line && !line_r)
    begin
      node_nxt.node_request_bit = 1'b1;
    end
    irq_nxt = node_nxt.node_request_bit & node_nxt.node_enable_bit;
  end

  always_ff @(posedge CLK_IN or negedge rst_b_r)
  begin
    if (!rst_b_r)
    begin
      node_r    <= rtcc_pkg::rtcc_node_t'(`RTCC_NODE_RST);
      srst_r    <= 1'b0;
      line_r    <= 1'b0;
      irq_r     <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      node_r    <= node_nxt;
      srst_r    <= srst_nxt;
      line_r    <= line_nxt;
      irq_r     <= irq_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign PRDATA_OUT  = prdata_r;
  assign PREADY_OUT  = pready_r;
  assign PSLVERR_OUT = pslverr_r;
  assign IRQ_OUT     = irq_r;

endmodule : rtcc_top
`default_nettype wire

// File: tb/rtcc_properties.sv
// Checker of the chain's bus and interrupt ports.
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_regs.svh"
module rtcc_properties (
  input wire logic        CLK_IN,
  input wire logic        RST_B_IN,
  input wire logic        IRQ_ACK_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [15:0] PADDR_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic        IRQ_OUT
);
  logic node_wr;
  assign node_wr = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PADDR_IN == `RTCC_OFF_NODE;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  sequence setup_s;
    PSEL_IN && !PENABLE_IN;
  endsequence
  sequence rd_s(a);
    PREADY_OUT && !PWRITE_IN && PADDR_IN == a;
  endsequence
  pready_after_setup_a: assert property (setup_s |=> PREADY_OUT) else $error("No ready after setup.");
  pready_single_a: assert property (PREADY_OUT |=> !PREADY_OUT) else $error("Ready held too long.");
  slverr_with_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT) else $error("Error without ready.");
  error_data_zero_a: assert property (PSLVERR_OUT && !PWRITE_IN |-> PRDATA_OUT == 32'h0)
    else $error("Refused read returned data.");
  upper_half_zero_a: assert property (rd_s(PADDR_IN) |-> PRDATA_OUT[31:16] == 16'h0)
    else $error("Upper read half not zero.");
  subnode_unused_a: assert property (rd_s(`RTCC_OFF_SUBNODE) |-> PRDATA_OUT[15:10] == 6'h0)
    else $error("Unused subnode bits set.");
  node_unused_a: assert property (rd_s(`RTCC_OFF_NODE) |-> PRDATA_OUT[15:9] == 7'h0)
    else $error("Unused node bits set.");
  irq_drop_cause_a: assert property ($fell(IRQ_OUT) |-> $past(IRQ_ACK_IN) || $past(node_wr))
    else $error("Interrupt dropped without cause.");
  irq_reset_low_a: assert property ($rose(RST_B_IN) |-> !IRQ_OUT ##1 !IRQ_OUT)
    else $error("Interrupt high after reset.");
endmodule : rtcc_properties
bind rtcc_top rtcc_properties i_chk (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .IRQ_ACK_IN(IRQ_ACK_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .IRQ_OUT(IRQ_OUT));
`default_nettype wire

// File: tb/rtcc_cpu_model.sv
// Interrupt controller model that vectors to the handler some cycles after the line rises.
`timescale 1ns/1ps
`default_nettype none
module rtcc_cpu_model (
  input  wire logic clk_in,
  input  wire logic irq_in,
  output var  logic ack_out
);
  logic [2:0] dly_r = 3'h0;
  initial ack_out = 1'b0;
  always @(posedge clk_in)
  begin
    if (irq_in !== 1'b1)
      dly_r <= 3'h0;
    else if (dly_r != 3'h7)
      dly_r <= dly_r + 3'h1;
    ack_out <= irq_in === 1'b1 && dly_r == 3'h5;
  end
endmodule : rtcc_cpu_model
`default_nettype wire

// File: tb/rtc_timer_chain_irq_tb_top.sv
// Self-checking bench of the chain: registers, counting and interrupts.
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_regs.svh"
module rtc_timer_chain_irq_tb_top;
  localparam int DIV = 4;
  typedef struct {string nm; logic [31:0] d; logic e;} rtcc_note_t;
  logic        clk = 1'b0, rst_b = 1'b0, tick = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        ack, pready, pslverr, irq;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  int          bad_count = 0, cmp_count = 0, seed = 32'h6d55;
  rtcc_note_t  q[$], note;
  always #4 clk = ~clk;
  rtcc_top #(.PRESCALE_DIV(DIV)) i_dut (.CLK_IN(clk), .RST_B_IN(rst_b), .RTC_TICK_IN(tick), .IRQ_ACK_IN(ack),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .IRQ_OUT(irq));
  rtcc_cpu_model i_cpu (.clk_in(clk), .irq_in(irq), .ack_out(ack));
  task automatic check(string nm, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic complete_run;
    $display("Compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic give_up;
    bad_count++;
    complete_run();
  endtask : give_up
  task automatic apb(logic w, logic [15:0] a, logic [31:0] d, logic e = 1'b0, string nm = "");
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      q.push_back('{nm, d, e});
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (k == 16)
      give_up();
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic ticks(int m);
    repeat (m)
    begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      repeat ($unsigned($random(seed)) % 3) @(posedge clk);
    end
  endtask : ticks
  task automatic see_irq(logic v);
    int k;
    for (k = 0; k < 40 && irq !== v; k++) @(posedge clk);
    if (k == 40)
      give_up();
  endtask : see_irq
  always @(posedge clk)
    if (psel && pen && pready === 1'b1 && !pwr)
    begin
      note = q.pop_front();
      check(note.nm, prdata, note.d);
      check({note.nm, " error"}, {31'h0, pslverr}, {31'h0, note.e});
    end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1, `RTCC_OFF_CTRL, 32'h4);
    apb(0, `RTCC_OFF_CTRL, 32'h3, 0, "ctrl");
    apb(0, `RTCC_OFF_SUBNODE, 32'h0, 0, "subnode");
    apb(0, `RTCC_OFF_NODE, 32'h0, 0, "node");
    apb(0, `RTCC_OFF_PRESCALER, 32'h0, 0, "prescaler");
    apb(0, `RTCC_OFF_COUNT_HI, 32'h0, 0, "count hi");
    apb(0, 16'h0020, 32'h0, 1, "unmapped");
    ticks(16);
    apb(0, `RTCC_OFF_PRESCALER, 16 / DIV, 0, "divided");
    r = {16'h0, 16'($random(seed))};
    apb(1, `RTCC_OFF_RELOAD_HI, r);
    apb(0, `RTCC_OFF_RELOAD_HI, r, 0, "reload hi");
    apb(1, `RTCC_OFF_CTRL, 32'h0);
    apb(1, `RTCC_OFF_PRE_RELOAD, 32'hfffc);
    apb(1, `RTCC_OFF_PRESCALER, 32'hfffc);
    apb(1, `RTCC_OFF_RELOAD_LO, 32'h03fe);
    apb(1, `RTCC_OFF_COUNT_LO, 32'h03fe);
    ticks(3);
    apb(1, `RTCC_OFF_CTRL, 32'h1);
    ticks(8);
    apb(0, `RTCC_OFF_COUNT_LO, 32'h07fe, 0, "count lo");
    apb(0, `RTCC_OFF_PRESCALER, 32'hfffc, 0, "prescaler");
    apb(0, `RTCC_OFF_SUBNODE, 32'h000a, 0, "flags");
    apb(1, `RTCC_OFF_NODE, 32'h0040);
    apb(1, `RTCC_OFF_SUBNODE, 32'h0001);
    ticks(4);
    see_irq(1);
    see_irq(0);
    apb(0, `RTCC_OFF_NODE, 32'h0040, 0, "node acked");
    apb(0, `RTCC_OFF_SUBNODE, 32'h0003, 0, "flags kept");
    apb(1, `RTCC_OFF_SUBNODE, 32'h0000);
    ticks(4);
    repeat (4) @(posedge clk);
    check("masked irq", {31'h0, irq}, 32'h0);
    apb(0, `RTCC_OFF_SUBNODE, 32'h000a, 0, "masked flags");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    apb(0, `RTCC_OFF_NODE, 32'h0, 0, "node reset");
    apb(0, `RTCC_OFF_COUNT_LO, 32'h0bfe, 0, "count kept");
    apb(0, `RTCC_OFF_SUBNODE, 32'h000a, 0, "subnode kept");
    apb(1, `RTCC_OFF_CTRL, 32'h4);
    apb(1, `RTCC_OFF_CTRL, 32'h1);
    apb(1, `RTCC_OFF_PRESCALER, 32'hffff);
    apb(1, `RTCC_OFF_COUNT_LO, 32'hffff);
    ticks(1);
    apb(0, `RTCC_OFF_PRESCALER, 32'h0, 0, "zero reload");
    apb(0, `RTCC_OFF_COUNT_LO, 32'h0, 0, "binary lo");
    apb(0, `RTCC_OFF_COUNT_HI, 32'h1, 0, "binary hi");
    apb(0, `RTCC_OFF_SUBNODE, 32'h002a, 0, "chain flags");
    apb(1, `RTCC_OFF_PRE_RELOAD, 32'hf9c0);
    apb(1, `RTCC_OFF_PRESCALER, 32'hffff);
    ticks(1);
    apb(0, `RTCC_OFF_PRESCALER, 32'hf9c0, 0, "tick reload");
    apb(0, `RTCC_OFF_COUNT_LO, 32'h1, 0, "tick count");
    complete_run();
  end
endmodule : rtc_timer_chain_irq_tb_top
`default_nettype wire
